// [hdl/acp_pkg.sv]
package acp_pkg;

   // register byte offsets on the Avalon-MM slave
   localparam logic [3:0] CTRL_OFS   = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam logic [3:0] CONFIG_OFS = 4'h8;
   localparam logic [3:0] RESULT_OFS = 4'hC;

   // field positions
   localparam int CTRL_START_BIT  = 0;
   localparam int STAT_BUSY_BIT   = 0;
   localparam int STAT_WORD_BIT   = 1;
   localparam int STAT_SEL_BIT    = 2;
   localparam int STAT_MODE_LSB   = 4;
   localparam int CFG_RANGE_LSB   = 0;
   localparam int CFG_RANGE_W     = 2;
   localparam int PIN_RANGE_LSB   = 0;
   localparam int PIN_SEL_BIT     = 2;
   localparam int PIN_MODE_LSB    = 3;
   localparam int PIN_W           = 5;
   localparam int PAR_SHARED_LSB  = 15;
   localparam int RESULT_BITS     = 18;

   // reset values
   localparam logic [7:0]  CFG_RESET_VAL = 8'h00;
   localparam logic [31:0] RDATA_IDLE    = 32'h0000_0000;

   // interface mode that turns the shared pins into the configuration port
   localparam logic [1:0] MODE_SERIAL = 2'h3;

   // timing: clock rate and conversion times, least times round up
   localparam int CLK_MHZ      = 10;
   localparam int CONV_TIME_NS = 700;
   localparam int XFER_TIME_NS = 500;
   localparam int CONV_CYCLES  = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int XFER_CYCLES  = (XFER_TIME_NS * CLK_MHZ + 999) / 1000;

   // conversion sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_CONV = 2'b10
   } acp_conv_t;

endpackage

// [hdl/acp_cfg_port.sv]
`timescale 1ns/100ps
// How it works
// RULE1: in serial mode the source-select pin decides whether setup comes from pins or software.
// RULE2: with source select low the setup is taken from the serial configuration register; the code does so in mode 3 only, in modes 0 to 2 it takes the pins.
// RULE3: with source select high the setup is taken from the hardware pins only.
// RULE4: in modes 0 to 2 the three shared pins drive result bits 15, 16 and 17.
// RULE5: the host shifts the configuration word in most significant bit first.
// RULE6: each data bit is captured on the clock edge chosen by the clock-invert pin.
// RULE7: the port select enables the port and bits are taken only while it is asserted.
// RULE8: busy rises at conversion start and falls once the result is latched.
// RULE9: the host may use the falling edge of busy as its data-ready strobe.
// RULE10: in mode 3 the busy time is lengthened to cover the output transfer.
// RULE11: reset clears the configuration register to its default and zeroes the data outputs.
// RULE12: the port select is active low and a partly shifted word is dropped when it rises.
module acp_cfg_port #(
   parameter int CFG_BITS = 8,
   parameter logic [CFG_BITS-1:0] CFG_DEFAULT = CFG_BITS'(acp_pkg::CFG_RESET_VAL),
   parameter int CONV_CYC = acp_pkg::CONV_CYCLES,
   parameter int XFER_CYC = acp_pkg::XFER_CYCLES
) (
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   // device pins
   input  wire logic [1:0]  mode_in,
   input  wire logic        config_source_select_in,
   input  wire logic [1:0]  hw_range_in,
   input  wire logic        serial_clock_invert_in,
   input  wire logic        par_bit_15_in,
   output logic             par_bit_15_out,
   output logic             par_bit_15_oe_out,
   input  wire logic        par_bit_16_in,
   output logic             par_bit_16_out,
   output logic             par_bit_16_oe_out,
   input  wire logic        par_bit_17_in,
   output logic             par_bit_17_out,
   output logic             par_bit_17_oe_out,
   // converter core side
   input  wire logic [17:0] conv_data_in,
   output logic             busy_out,
   output logic [1:0]       setup_out
);

   localparam int CNT_W  = $clog2(CONV_CYC + XFER_CYC + 1);
   localparam int BCNT_W = $clog2(CFG_BITS);

   // parameter sanity
   if (CFG_BITS < acp_pkg::CFG_RANGE_W + 1 || CFG_BITS > 32)
      $error("acp_cfg_port: CFG_BITS must lie between 3 and 32");
   if (CONV_CYC < 1 || XFER_CYC < 1)
      $error("acp_cfg_port: conversion counts must be at least one cycle");

   typedef struct packed {
      logic [acp_pkg::PIN_W-1:0]       pin_s1;
      logic [acp_pkg::PIN_W-1:0]       pin_s2;
      logic                            tog_s1;
      logic                            tog_s2;
      logic                            tog_s3;
      logic [CFG_BITS-1:0]             cfg;
      logic                            word_flag;
      acp_pkg::acp_conv_t              st;
      logic [CNT_W-1:0]                cnt;
      logic [acp_pkg::RESULT_BITS-1:0] result;
      logic [2:0]                      par_out;
      logic                            par_oe;
      logic [1:0]                      setup;
      logic                            waitreq;
      logic [31:0]                     rdata;
   } acp_main_t;

   typedef struct packed {
      logic [CFG_BITS-1:0] sh;
      logic [CFG_BITS-1:0] hold;
      logic                tog;
   } acp_link_t;

   logic [1:0]        rst_sync_reg;
   logic              rst_sync_n;
   acp_main_t         m_reg;
   acp_main_t         m_next;
   acp_link_t         l_reg;
   acp_link_t         l_next;
   logic [BCNT_W-1:0] bcnt_reg;
   logic              link_clk;
   logic              link_arst_n;
   logic              word_done;

   // all checks below run on the main clock and sleep through reset
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_sync_n);

   // reset release through two flops
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_sync_n = rst_sync_reg[1];

   // link side: shared pins become the configuration clock, data and select
   assign link_clk    = par_bit_16_in ^ serial_clock_invert_in;   // RULE6
   assign link_arst_n = rst_sync_n & ~par_bit_17_in;               // RULE7 RULE12
   assign word_done   = (bcnt_reg == BCNT_W'(CFG_BITS - 1));

   // bit counter, held cleared while the select is high so a short word is lost
   always_ff @(posedge link_clk or negedge link_arst_n) begin
      if (!link_arst_n) begin
         bcnt_reg <= '0;                                           // RULE12
      end else if (word_done) begin
         bcnt_reg <= '0;
      end else begin
         bcnt_reg <= bcnt_reg + BCNT_W'(1);
      end
   end

   // shift register and word hand-off toggle
   always_comb begin
      l_next    = l_reg;
      l_next.sh = {l_reg.sh[CFG_BITS-2:0], par_bit_15_in};         // RULE5 RULE6
      if (word_done && !par_bit_17_in) begin                       // RULE7
         l_next.hold = {l_reg.sh[CFG_BITS-2:0], par_bit_15_in};
         l_next.tog  = ~l_reg.tog;
      end
   end

   always_ff @(posedge link_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         l_reg <= '0;
      end else begin
         l_reg <= l_next;
      end
   end

   // main side next state
   always_comb begin
      logic       serial_mode;
      logic       sw_cfg;
      logic       new_word;
      logic       req;
      logic       take;
      logic       word_clr;
      logic [1:0] pmode;
      m_next      = m_reg;
      pmode       = m_reg.pin_s2[acp_pkg::PIN_MODE_LSB +: 2];
      serial_mode = (pmode == acp_pkg::MODE_SERIAL);
      sw_cfg      = serial_mode && !m_reg.pin_s2[acp_pkg::PIN_SEL_BIT];   // RULE1
      new_word    = m_reg.tog_s2 ^ m_reg.tog_s3;
      req         = avs_read_in | avs_write_in;
      take        = req && !m_reg.waitreq;
      word_clr    = 1'b0;

      // pin synchronisers and toggle detector
      m_next.pin_s1 = {mode_in, config_source_select_in, hw_range_in};
      m_next.pin_s2 = m_reg.pin_s1;
      m_next.tog_s1 = l_reg.tog;
      m_next.tog_s2 = m_reg.tog_s1;
      m_next.tog_s3 = m_reg.tog_s2;

      // a finished word loads only in software configuration mode
      if (new_word && sw_cfg) begin                                // RULE7
         m_next.cfg = l_reg.hold;                                  // RULE2
      end

      // setup source selection
      if (sw_cfg) begin
         m_next.setup = m_reg.cfg[acp_pkg::CFG_RANGE_LSB +: 2];    // RULE2
      end else begin
         m_next.setup = m_reg.pin_s2[acp_pkg::PIN_RANGE_LSB +: 2]; // RULE3
      end

      // shared pins: outputs in parallel modes, released in serial mode
      m_next.par_oe  = !serial_mode;                               // RULE4
      m_next.par_out = m_reg.result[acp_pkg::PAR_SHARED_LSB +: 3]; // RULE4

      // bus handshake: one wait cycle, then accept
      m_next.waitreq = !(req && m_reg.waitreq);
      m_next.rdata   = acp_pkg::RDATA_IDLE;
      if (avs_read_in && m_reg.waitreq) begin
         unique case (avs_address_in)
            acp_pkg::CTRL_OFS: begin
               m_next.rdata[acp_pkg::CTRL_START_BIT] = (m_reg.st == acp_pkg::ST_CONV);
            end
            acp_pkg::STATUS_OFS: begin
               m_next.rdata[acp_pkg::STAT_BUSY_BIT]      = (m_reg.st == acp_pkg::ST_CONV);
               m_next.rdata[acp_pkg::STAT_WORD_BIT]      = m_reg.word_flag;
               m_next.rdata[acp_pkg::STAT_SEL_BIT]       = m_reg.pin_s2[acp_pkg::PIN_SEL_BIT];
               m_next.rdata[acp_pkg::STAT_MODE_LSB +: 2] = pmode;
            end
            acp_pkg::CONFIG_OFS: begin
               m_next.rdata[CFG_BITS-1:0] = m_reg.cfg;
            end
            acp_pkg::RESULT_OFS: begin
               m_next.rdata[acp_pkg::RESULT_BITS-1:0] = m_reg.result;
            end
            default: begin
               m_next.rdata = acp_pkg::RDATA_IDLE;
            end
         endcase
      end
      if (take && avs_write_in && avs_address_in == acp_pkg::STATUS_OFS) begin
         word_clr = avs_writedata_in[acp_pkg::STAT_WORD_BIT];
      end

      // word-received flag, a new word beats a clear in the same cycle
      m_next.word_flag = (new_word && sw_cfg) || (m_reg.word_flag && !word_clr);

      // conversion sequencer
      unique case (m_reg.st)
         acp_pkg::ST_IDLE: begin
            if (take && avs_write_in && avs_address_in == acp_pkg::CTRL_OFS
                && avs_writedata_in[acp_pkg::CTRL_START_BIT]) begin
               m_next.st = acp_pkg::ST_CONV;                       // RULE8
               if (serial_mode) begin
                  m_next.cnt = CNT_W'(CONV_CYC + XFER_CYC);        // RULE10
               end else begin
                  m_next.cnt = CNT_W'(CONV_CYC);
               end
            end
         end
         acp_pkg::ST_CONV: begin
            m_next.cnt = m_reg.cnt - CNT_W'(1);
            if (m_reg.cnt == CNT_W'(1)) begin
               m_next.result = conv_data_in;                       // RULE8
               m_next.st     = acp_pkg::ST_IDLE;                   // RULE9
            end
         end
      endcase
   end

   // main register, reset clears configuration and data outputs
   always_ff @(posedge clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         m_reg         <= '0;                                      // RULE11
         m_reg.cfg     <= CFG_DEFAULT;                             // RULE11
         m_reg.st      <= acp_pkg::ST_IDLE;
         m_reg.waitreq <= 1'b1;
      end else begin
         m_reg <= m_next;
      end
   end

   // outputs straight from flops
   assign avs_readdata_out    = m_reg.rdata;
   assign avs_waitrequest_out = m_reg.waitreq;
   assign busy_out            = m_reg.st[1];
   assign setup_out           = m_reg.setup;
   assign par_bit_15_out      = m_reg.par_out[0];
   assign par_bit_16_out      = m_reg.par_out[1];
   assign par_bit_17_out      = m_reg.par_out[2];
   assign par_bit_15_oe_out   = m_reg.par_oe;
   assign par_bit_16_oe_out   = m_reg.par_oe;
   assign par_bit_17_oe_out   = m_reg.par_oe;

   // checks
   logic [CNT_W:0] busy_len_reg;
   logic           smode_at_start_reg;
   logic           serial_now;
   logic           sw_now;
   logic           word_now;

   assign serial_now = (m_reg.pin_s2[acp_pkg::PIN_MODE_LSB +: 2] == acp_pkg::MODE_SERIAL);
   assign sw_now     = serial_now && !m_reg.pin_s2[acp_pkg::PIN_SEL_BIT];
   assign word_now   = m_reg.tog_s2 ^ m_reg.tog_s3;

   // busy length counter and mode at conversion start
   always_ff @(posedge clk_in or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         busy_len_reg       <= '0;
         smode_at_start_reg <= 1'b0;
      end else begin
         if (busy_out) begin
            busy_len_reg <= busy_len_reg + (CNT_W+1)'(1);
         end else begin
            busy_len_reg       <= '0;
            smode_at_start_reg <= serial_now;
         end
      end
   end

   property p_sel_parallel;
      !serial_now |=> setup_out == $past(m_reg.pin_s2[1:0]);
   endproperty
   a_sel_parallel: assert property (p_sel_parallel) else $error("setup not from pins"); // RULE1

   property p_setup_sw;
      sw_now |=> setup_out == $past(m_reg.cfg[1:0]);
   endproperty
   a_setup_sw: assert property (p_setup_sw) else $error("setup not from register"); // RULE2

   property p_setup_hw;
      (serial_now && m_reg.pin_s2[acp_pkg::PIN_SEL_BIT]) |=> setup_out == $past(hw_sync2());
   endproperty
   a_setup_hw: assert property (p_setup_hw) else $error("setup ignored pins"); // RULE3

   property p_par_drive;
      !serial_now |=> par_bit_15_oe_out && par_bit_17_out == $past(m_reg.result[17]);
   endproperty
   a_par_drive: assert property (p_par_drive) else $error("shared pins not driving"); // RULE4

   property p_cfg_load;
      (word_now && sw_now) |=> m_reg.cfg == $past(l_reg.hold) && m_reg.word_flag;
   endproperty
   a_cfg_load: assert property (p_cfg_load) else $error("word not loaded"); // RULE2

   property p_cfg_refuse;
      (word_now && !sw_now) |=> $stable(m_reg.cfg);
   endproperty
   a_cfg_refuse: assert property (p_cfg_refuse) else $error("word taken outside sw mode"); // RULE7

   property p_busy_short;
      ($fell(busy_out) && !smode_at_start_reg) |-> busy_len_reg == (CNT_W+1)'(CONV_CYC);
   endproperty
   a_busy_short: assert property (p_busy_short) else $error("busy length wrong"); // RULE8

   property p_busy_long;
      ($fell(busy_out) && smode_at_start_reg)
         |-> busy_len_reg == (CNT_W+1)'(CONV_CYC + XFER_CYC);
   endproperty
   a_busy_long: assert property (p_busy_long) else $error("serial busy length wrong"); // RULE10

   property p_result_latch;
      $fell(busy_out) |-> m_reg.result == $past(conv_data_in);
   endproperty
   a_result_latch: assert property (p_result_latch) else $error("result not latched"); // RULE8

   c_conv_par:   cover property ($fell(busy_out) && !smode_at_start_reg);
   c_conv_ser:   cover property ($fell(busy_out) && smode_at_start_reg);
   c_word_load:  cover property (word_now && sw_now);
   c_word_drop:  cover property (word_now && !sw_now);

   function automatic logic [1:0] hw_sync2();
      return m_reg.pin_s2[acp_pkg::PIN_RANGE_LSB +: 2];
   endfunction

endmodule

// [verif/acp_host_model.sv]
`timescale 1ns/100ps
// host side of the configuration link: drives data, link clock and active-low select
module acp_host_model (
   input  wire logic inv_in,
   output logic      sdata_out,
   output logic      sclk_out,
   output logic      sel_n_out
);
   // idle: deselected, link clock parked, no free-running clock between frames
   initial begin
      sdata_out = 1'b0;
      sclk_out  = 1'b0;
      sel_n_out = 1'b1;
   end

   // shifts the top n bits of w, one bit per 160 ns link clock period
   task automatic send(input logic [7:0] w, input int n);
      sclk_out = inv_in;
      #37 sel_n_out = 1'b0;
      for (int i = 7; i > 7 - n; i--) begin
         sdata_out = w[i];
         #80 sclk_out = ~inv_in;
         #80 sclk_out = inv_in;
      end
      // releasing early abandons a short word
      #40 sel_n_out = 1'b1;
      sdata_out = ~sdata_out;
   endtask
endmodule

// [verif/adc_serial_config_port_busy_tb.sv]
`timescale 1ns/100ps
module adc_serial_config_port_busy_tb;
   logic        clk_in;
   logic        rst_n_in;
   logic [3:0]  addr;
   logic        rd;
   logic        wr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        waitreq;
   logic [1:0]  mode;
   logic        src_sel;
   logic [1:0]  hw_range;
   logic        inv;
   logic [2:0]  pout;
   logic [2:0]  poe;
   logic [2:0]  host;
   logic [2:0]  pin;
   logic [17:0] conv_data;
   logic        busy;
   logic [1:0]  setup;
   int          n_mismatch;
   int          n_checks;

   // shared pins: the device wins while it drives, the host otherwise
   assign pin = (poe & pout) | (~poe & host);

   acp_cfg_port acp_cfg_port_i (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(addr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
      .avs_waitrequest_out(waitreq), .mode_in(mode), .config_source_select_in(src_sel),
      .hw_range_in(hw_range), .serial_clock_invert_in(inv),
      .par_bit_15_in(pin[0]), .par_bit_15_out(pout[0]), .par_bit_15_oe_out(poe[0]),
      .par_bit_16_in(pin[1]), .par_bit_16_out(pout[1]), .par_bit_16_oe_out(poe[1]),
      .par_bit_17_in(pin[2]), .par_bit_17_out(pout[2]), .par_bit_17_oe_out(poe[2]),
      .conv_data_in(conv_data), .busy_out(busy), .setup_out(setup)
   );

   acp_host_model acp_host_model_i (
      .inv_in(inv), .sdata_out(host[0]), .sclk_out(host[1]), .sel_n_out(host[2])
   );

   // main clock, 100 ns
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // one Avalon-MM cycle, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int i;
      @(posedge clk_in);
      rd <= ~w;
      wr <= w;
      addr <= a;
      wdata <= d;
      for (i = 0; i < 20; i++) begin
         @(posedge clk_in);
         if (waitreq === 1'b0) break;
      end
      q = rdata;
      if (i == 20) begin
         n_mismatch++;
         summarize();
      end
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   // sets the pins at an edge and lets the synchronisers settle
   task automatic pins(input logic [1:0] m, input logic s, input logic [1:0] r, input logic v);
      @(posedge clk_in);
      mode <= m;
      src_sel <= s;
      hw_range <= r;
      inv <= v;
      repeat (6) @(posedge clk_in);
   endtask

   // one conversion, busy timed in sampled cycles
   task automatic t_conv(input logic [1:0] m, input int exp_n);
      logic [31:0] q;
      int          n;
      n = 0;
      pins(m, 1'b0, 2'h1, 1'b0);
      conv_data <= conv_data + 18'h12345;
      bus(1'b1, acp_pkg::CTRL_OFS, 32'h1, q);
      for (int i = 0; i < 40 && !(n > 0 && busy === 1'b0); i++) begin
         #1;
         if (busy === 1'b1) n++;
         @(posedge clk_in);
      end
      chk("busy cycles", 32'(n), 32'(exp_n));
      repeat (2) @(posedge clk_in);
      #1;
      chk("pin enables", {29'h0, poe}, (m == 2'h3) ? 32'h0 : 32'h7);
      chk("conv setup", {30'h0, setup}, (m == 2'h3) ? 32'h0 : 32'h1);
      if (m != 2'h3) chk("shared pins", {29'h0, pin}, {29'h0, conv_data[17:15]});
      bus(1'b0, acp_pkg::RESULT_OFS, 32'h0, q);
      chk("result", q, {14'h0, conv_data});
      $display("conversion test mode %0d done", m);
   endtask

   // one configuration frame, then config register and effective setup
   task automatic t_cfg(input logic s, input logic v, input logic [7:0] w, input int n,
                        input logic [7:0] exp, input logic [1:0] exp_set);
      logic [31:0] q;
      logic        exp_flag;
      exp_flag = (n == 8) && !s;
      pins(2'h3, s, 2'h3, v);
      acp_host_model_i.send(w, n);
      repeat (10) @(posedge clk_in);
      bus(1'b0, acp_pkg::CONFIG_OFS, 32'h0, q);
      chk("config", q, {24'h0, exp});
      chk("setup", {30'h0, setup}, {30'h0, exp_set});
      bus(1'b0, acp_pkg::STATUS_OFS, 32'h0, q);
      chk("status", q, {26'h0, 2'h3, 1'b0, s, exp_flag, 1'b0});
      // clear the word flag so the next frame starts from zero
      bus(1'b1, acp_pkg::STATUS_OFS, 32'h2, q);
      $display("config test word %h done", w);
   endtask

   // reset in mid-run after a word was loaded
   task automatic t_rst();
      logic [31:0] q;
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      #1;
      chk("pins in reset", {29'h0, pout}, 32'h0);
      @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      bus(1'b0, acp_pkg::CONFIG_OFS, 32'h0, q);
      chk("config after reset", q, {24'h0, acp_pkg::CFG_RESET_VAL});
      bus(1'b0, acp_pkg::RESULT_OFS, 32'h0, q);
      chk("result after reset", q, 32'h0);
      bus(1'b0, 4'h2, 32'h0, q);
      chk("unmapped read", q, 32'h0);
      $display("reset test done");
   endtask

   // main sequence
   initial begin
      rst_n_in = 1'b0;
      addr = 4'h0;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 32'h0;
      mode = 2'h0;
      src_sel = 1'b0;
      hw_range = 2'h0;
      inv = 1'b0;
      conv_data = 18'h2A5C3;
      n_mismatch = 0;
      n_checks = 0;
      repeat (8) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      t_conv(2'h0, acp_pkg::CONV_CYCLES);
      t_conv(2'h2, acp_pkg::CONV_CYCLES);
      t_conv(2'h3, acp_pkg::CONV_CYCLES + acp_pkg::XFER_CYCLES);
      t_cfg(1'b0, 1'b0, 8'hA5, 8, 8'hA5, 2'h1);
      t_cfg(1'b0, 1'b1, 8'h36, 8, 8'h36, 2'h2);
      t_cfg(1'b0, 1'b0, 8'hFF, 5, 8'h36, 2'h2);
      t_cfg(1'b1, 1'b0, 8'h00, 8, 8'h36, 2'h3);
      t_rst();
      summarize();
   end
endmodule
